//--- gdio_in_if.sv
// Carrier between the port core and its input synchroniser.
`timescale 1ns/1ps
interface gdio_in_if #(
  parameter int N_PINS = 8
);
  logic [N_PINS-1:0] pin_level;
  logic              clamp_req;
  logic [N_PINS-1:0] clamp_keep;
  logic [N_PINS-1:0] sample;

  modport core (
    output pin_level,
    output clamp_req,
    output clamp_keep,
    input  sample
  );

  modport sync (
    input  pin_level,
    input  clamp_req,
    input  clamp_keep,
    output sample
  );
endinterface

//--- gdio_in_sync.sv
// Input clamp and two-stage pin synchroniser of the digital I/O port.
`timescale 1ns/1ps
module gdio_in_sync
  import gdio_port_pkg::*;
#(
  parameter int N_PINS = 8
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // Link to the port core
  gdio_in_if.sync   io_in
);

  logic [N_PINS-1:0] clamped;
  logic [N_PINS-1:0] catch_lo;
  logic [N_PINS-1:0] sample_r;

  genvar g;
  generate
    for (g = 0; g < N_PINS; g++) begin : g_pin
      // The clamp sits ahead of the first stage, so a floating pin never toggles it while clamped.
      assign clamped[g] = io_in.pin_level[g] & ~(io_in.clamp_req & ~io_in.clamp_keep[g]);

      // First stage closes on the falling edge, like a latch open while the clock is high.
      always_ff @(negedge i_clk_sys) begin
        catch_lo[g] <= clamped[g];
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          sample_r[g] <= 1'b0;
        end else begin
          sample_r[g] <= catch_lo[g];
        end
      end
    end
  endgenerate

  assign io_in.sample = sample_r;

endmodule

//--- gdio_pin_model.sv
// Behavioural model of the pads and what drives them from outside.
`timescale 1ns/1ps
module gdio_pin_model #(
  parameter int N_PINS = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic [N_PINS-1:0] i_pin_out,
  input  wire logic [N_PINS-1:0] i_pin_oe_n,
  input  wire logic [N_PINS-1:0] i_pullup_en,
  input  wire logic [N_PINS-1:0] i_ext_en,
  input  wire logic [N_PINS-1:0] i_ext_val,
  output logic      [N_PINS-1:0] o_pin_level
);
  logic [N_PINS-1:0] float_r = '0;
  // An undriven pad flips every cycle so a stale level never passes for a read.
  always @(posedge i_clk_sys) float_r <= ~float_r;
  assign o_pin_level = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & ((i_ext_en & i_ext_val)
    | (~i_ext_en & (i_pullup_en | float_r))));
endmodule

//--- gdio_port.sv
// General-purpose digital I/O port with APB register access.
//
// Function
// - Each pin has direction, output value, pull-up and input sample bits.
// - Direction one makes the pin an output, zero an input.
// - An output pin drives its output value bit onto the pin.
// - Pull-up bit one turns the pull-up on; input without pull-up floats.
// - Pull-up works regardless of direction, also on a driven output.
// - Reset releases every pin at once, even without a clock.
// - Writing one to the input sample location toggles the output bit.
// - With break-before-make, input to output waits one released cycle.
// - One enable bit selects break-before-make for the whole port.
// - Output to input releases the pin without extra delay.
// - Pin level reads through a two-stage synchroniser whatever the direction.
// - First stage captures at falling edge, sample loads at next rising edge.
// - Sleep controller clamps digital inputs to ground in deep sleep.
// - Pins with enabled external interrupt or alternate function stay unclamped.
// - Clamp release on a high pin appears as a change to interrupt logic.
// - Inputs stay unclamped in reset, active and idle; reset disables pull-ups.
// - Sample bits are read-only, a write there toggles output bits; the other three are read-write.
`timescale 1ns/1ps
`include "gdio_port_map.svh"
module gdio_port
  import gdio_port_pkg::*;
#(
  parameter int N_PINS = 8
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Pins
  input  wire logic [N_PINS-1:0] i_pin_level,
  output logic      [N_PINS-1:0] o_pin_out,
  output logic      [N_PINS-1:0] o_pin_oe_n,
  output logic      [N_PINS-1:0] o_pullup_en,
  // Sleep controller and interrupt side
  input  wire logic              i_sleep_clamp,
  input  wire logic [N_PINS-1:0] i_ext_int_en,
  input  wire logic [N_PINS-1:0] i_alt_input_keep,
  output logic      [N_PINS-1:0] o_pin_sample
);

  generate
    if (N_PINS < 1 || N_PINS > `GDIO_MAX_PINS) begin : g_bad_width
      $error("gdio_port: N_PINS must lie between 1 and 8");
    end
  endgenerate

  localparam logic [N_PINS-1:0] DIR_RST    = N_PINS'(`GDIO_DIR_RST);
  localparam logic [N_PINS-1:0] OUT_RST    = N_PINS'(`GDIO_OUT_RST);
  localparam logic [N_PINS-1:0] PULLUP_RST = N_PINS'(`GDIO_PULLUP_RST);

  // Software-visible state.
  logic [N_PINS-1:0] dir_r;
  logic [N_PINS-1:0] out_r;
  logic [N_PINS-1:0] pullup_r;
  logic              bbm_r;
  // Direction as seen one cycle earlier, for break-before-make.
  logic [N_PINS-1:0] dir_prev_r;

  // Bus slave state.
  bus_state_t        bus_state_r;
  bus_state_t        bus_state_nxt;
  logic [31:0]       rdata_nxt;
  logic              addr_bad;
  logic              wr_fire;
  logic              wr_lane0;
  logic [N_PINS-1:0] wr_bits;

  // Input side.
  logic              clamp_eff;
  logic [N_PINS-1:0] sample_w;
  logic [N_PINS-1:0] drive_nxt;

  gdio_in_if #(.N_PINS(N_PINS)) in_link ();

  // Digital inputs are never clamped while reset is asserted.
  assign clamp_eff = i_sleep_clamp & ~i_sys_rst;

  assign in_link.pin_level  = i_pin_level;
  assign in_link.clamp_req  = clamp_eff;
  // External interrupt enables and other alternate functions keep the input alive.
  assign in_link.clamp_keep = i_ext_int_en | i_alt_input_keep;
  assign sample_w           = in_link.sample;

  gdio_in_sync #(
    .N_PINS (N_PINS)
  ) u_in_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .io_in     (in_link.sync)
  );

  // ---------------------------------------------------------------------
  // APB slave. Every access takes two wait states: pready rises in the
  // third access cycle, so prdata and pslverr can both come from flops.
  // ---------------------------------------------------------------------

  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE: begin
        if (i_psel && i_penable) begin
          bus_state_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_nxt = BUS_DONE;
      end
      BUS_DONE: begin
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  always_comb begin
    case (i_paddr)
      `GDIO_OFF_DIR,
      `GDIO_OFF_OUT,
      `GDIO_OFF_PULLUP,
      `GDIO_OFF_SAMPLE,
      `GDIO_OFF_CTRL,
      `GDIO_OFF_STATUS: addr_bad = 1'b0;
      default:          addr_bad = 1'b1;
    endcase
  end

  // Read data is gathered in the cycle before pready rises.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (i_paddr)
      `GDIO_OFF_DIR:    rdata_nxt[N_PINS-1:0] = dir_r;
      `GDIO_OFF_OUT:    rdata_nxt[N_PINS-1:0] = out_r;
      `GDIO_OFF_PULLUP: rdata_nxt[N_PINS-1:0] = pullup_r;
      `GDIO_OFF_SAMPLE: rdata_nxt[N_PINS-1:0] = sample_w;
      `GDIO_OFF_CTRL:   rdata_nxt[`GDIO_CTRL_BBM_BIT] = bbm_r;
      `GDIO_OFF_STATUS: begin
        rdata_nxt[`GDIO_STAT_CLAMP_BIT] = clamp_eff;
        rdata_nxt[`GDIO_STAT_DRIVE_LSB +: N_PINS] = ~o_pin_oe_n;
      end
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= (bus_state_r == BUS_ANSWER);
      o_pslverr <= (bus_state_r == BUS_ANSWER) & addr_bad;
      if (bus_state_r == BUS_ANSWER && !i_pwrite) begin
        o_prdata <= rdata_nxt;
      end else if (bus_state_r == BUS_DONE) begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // A write lands at the edge where the master sees pready high.
  assign wr_fire  = (bus_state_r == BUS_DONE) & i_psel & i_penable & i_pwrite & ~addr_bad;
  assign wr_lane0 = wr_fire & i_pstrb[0];
  assign wr_bits  = i_pwdata[N_PINS-1:0];

  // ---------------------------------------------------------------------
  // Port registers, one process per register.
  // ---------------------------------------------------------------------

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dir_r <= DIR_RST;
    end else if (wr_lane0 && i_paddr == `GDIO_OFF_DIR) begin
      dir_r <= wr_bits;
    end
  end

  // Ones written to the sample location flip the output bits; the sample
  // itself cannot be written, so the toggle is that location's only write.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      out_r <= OUT_RST;
    end else if (wr_lane0 && i_paddr == `GDIO_OFF_OUT) begin
      out_r <= wr_bits;
    end else if (wr_lane0 && i_paddr == `GDIO_OFF_SAMPLE) begin
      out_r <= out_r ^ wr_bits;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pullup_r <= PULLUP_RST;
    end else if (wr_lane0 && i_paddr == `GDIO_OFF_PULLUP) begin
      pullup_r <= wr_bits;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bbm_r <= `GDIO_BBM_RST;
    end else if (wr_lane0 && i_paddr == `GDIO_OFF_CTRL) begin
      bbm_r <= i_pwdata[`GDIO_CTRL_BBM_BIT];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dir_prev_r <= DIR_RST;
    end else begin
      dir_prev_r <= dir_r;
    end
  end

  // ---------------------------------------------------------------------
  // Pin drivers. These flops clear without the clock, so the pins let go
  // as soon as reset rises even if the clock has stopped.
  // ---------------------------------------------------------------------

  // A pin that just turned to output is held off for one more cycle when
  // break-before-make is on; turning to input needs no such gap.
  always_comb begin
    drive_nxt = dir_r & ~(dir_r & ~dir_prev_r & {N_PINS{bbm_r}});
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_oe_n <= {N_PINS{1'b1}};
    end else begin
      o_pin_oe_n <= ~drive_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_out <= {N_PINS{1'b0}};
    end else begin
      o_pin_out <= out_r;
    end
  end

  // Pull-ups follow their bits whatever the direction and are off in reset.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pullup_en <= {N_PINS{1'b0}};
    end else begin
      o_pullup_en <= pullup_r;
    end
  end

  // The interrupt side watches the synchronised level, so releasing the
  // clamp on a high pin shows up there as a rising change.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pin_sample <= {N_PINS{1'b0}};
    end else begin
      o_pin_sample <= sample_w;
    end
  end

endmodule

//--- gdio_port_chk.sv
// Concurrent checks on the ports of the digital I/O port.
`timescale 1ns/1ps
`include "gdio_port_map.svh"
module gdio_port_chk #(
  parameter int N_PINS = 8
) (
  input wire logic              i_clk_sys,
  input wire logic              i_sys_rst,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [7:0]        i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [3:0]        i_pstrb,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic [N_PINS-1:0] i_pin_level,
  input wire logic [N_PINS-1:0] o_pin_out,
  input wire logic [N_PINS-1:0] o_pin_oe_n,
  input wire logic [N_PINS-1:0] o_pullup_en,
  input wire logic              i_sleep_clamp,
  input wire logic [N_PINS-1:0] i_ext_int_en,
  input wire logic [N_PINS-1:0] i_alt_input_keep,
  input wire logic [N_PINS-1:0] o_pin_sample
);
  logic [N_PINS-1:0] dir_r;
  logic              bbm_r;
  wire logic         done;
  wire logic [N_PINS-1:0] wd;
  wire logic [N_PINS-1:0] keep;
  assign done = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0] && !o_pslverr;
  assign wd = i_pwdata[N_PINS-1:0];
  assign keep = i_ext_int_en | i_alt_input_keep;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  // Shadow copies let the break-before-make check see the old direction.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dir_r <= '0;
      bbm_r <= 1'b0;
    end else if (done && i_paddr == `GDIO_OFF_DIR) begin
      dir_r <= wd;
    end else if (done && i_paddr == `GDIO_OFF_CTRL) begin
      bbm_r <= i_pwdata[`GDIO_CTRL_BBM_BIT];
    end
  end
  sequence s_wr(logic [7:0] a);
    done && i_paddr == a;
  endsequence
  sequence s_answer;
    !o_pready ##1 !o_pready ##1 o_pready;
  endsequence
  a_ready_wait: assert property ($rose(i_penable) && i_psel |-> s_answer)
    else $error("ready late or early");
  a_err_unmapped: assert property (o_pready && i_paddr > 8'h14 |-> o_pslverr)
    else $error("no error on unmapped access");
  a_out_write: assert property (s_wr(`GDIO_OFF_OUT) |-> ##2 o_pin_out == $past(wd, 2))
    else $error("pin value differs from write");
  a_out_toggle: assert property (s_wr(`GDIO_OFF_SAMPLE) |-> ##2
    o_pin_out == ($past(o_pin_out) ^ $past(wd, 2)))
    else $error("toggle wrong");
  a_pull_write: assert property (s_wr(`GDIO_OFF_PULLUP) |-> ##2 o_pullup_en == $past(wd, 2))
    else $error("pull-up differs from write");
  a_dir_plain: assert property (s_wr(`GDIO_OFF_DIR) ##0 !bbm_r |-> ##2
    o_pin_oe_n == ~$past(wd, 2))
    else $error("direction not applied");
  a_dir_bbm: assert property (s_wr(`GDIO_OFF_DIR) ##0 bbm_r |-> ##2
    o_pin_oe_n == ~($past(wd, 2) & $past(dir_r, 2)) ##1 o_pin_oe_n == ~$past(wd, 3))
    else $error("break-before-make gap wrong");
  a_rst_float: assert property (disable iff (1'b0) i_sys_rst |->
    &o_pin_oe_n && o_pullup_en == '0)
    else $error("pins not released in reset");
  a_sample_path: assert property (($stable(i_pin_level) && !i_sleep_clamp) [*3] |->
    o_pin_sample == i_pin_level)
    else $error("sample differs from pin");
  a_clamp_low: assert property ((i_sleep_clamp && $stable(i_pin_level) && $stable(keep)) [*3]
    |-> o_pin_sample == (i_pin_level & keep))
    else $error("clamp wrong");
endmodule

bind gdio_port gdio_port_chk #(.N_PINS(N_PINS)) u_chk (
  .i_clk_sys, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_pin_level, .o_pin_out,
  .o_pin_oe_n, .o_pullup_en, .i_sleep_clamp, .i_ext_int_en, .i_alt_input_keep,
  .o_pin_sample
);

//--- gdio_port_map.svh
// Register offsets, field positions and reset values of the digital I/O port.
`ifndef GDIO_PORT_MAP_SVH
`define GDIO_PORT_MAP_SVH

// Byte addresses of the port-wide register locations.
`define GDIO_OFF_DIR      8'h00
`define GDIO_OFF_OUT      8'h04
`define GDIO_OFF_PULLUP   8'h08
`define GDIO_OFF_SAMPLE   8'h0c
`define GDIO_OFF_CTRL     8'h10
`define GDIO_OFF_STATUS   8'h14

// Field positions.
`define GDIO_CTRL_BBM_BIT        0
`define GDIO_STAT_CLAMP_BIT      0
`define GDIO_STAT_DRIVE_LSB      8

// Reset values of the software-written fields.
`define GDIO_DIR_RST      8'h00
`define GDIO_OUT_RST      8'h00
`define GDIO_PULLUP_RST   8'h00
`define GDIO_BBM_RST      1'b0

// Number of whole cycles a pin stays released when break-before-make applies.
`define GDIO_BBM_GAP_CYCLES 1

// Largest pin count one port location can hold.
`define GDIO_MAX_PINS     8

`endif

//--- gdio_port_pkg.sv
// Types shared by the digital I/O port modules.
package gdio_port_pkg;

  // Bus slave states, one-hot.
  typedef enum logic [2:0] {
    BUS_IDLE   = 3'b001,
    BUS_ANSWER = 3'b010,
    BUS_DONE   = 3'b100
  } bus_state_t;

  typedef logic [7:0] port_word_t;

endpackage

//--- general_digital_io_port_test.sv
// Self-checking testbench of the digital I/O port.
`timescale 1ns/1ps
`include "gdio_port_map.svh"
module general_digital_io_port_test;
  logic        i_clk_sys, i_sys_rst, i_psel, i_penable, i_pwrite, i_sleep_clamp;
  logic [7:0]  i_paddr, i_pin_level, o_pin_out, o_pin_oe_n, o_pullup_en, o_pin_sample;
  logic [31:0] i_pwdata, o_prdata, rdata;
  logic [3:0]  i_pstrb;
  logic        o_pready, o_pslverr, serr;
  logic [7:0]  i_ext_int_en, i_alt_input_keep, ext_en, ext_val;
  logic [7:0]  regs [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
  int          err_count = 0;
  int          cmp_count = 0;

  gdio_port #(.N_PINS(8)) u_dut (
    .i_clk_sys, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_pin_level, .o_pin_out,
    .o_pin_oe_n, .o_pullup_en, .i_sleep_clamp, .i_ext_int_en, .i_alt_input_keep,
    .o_pin_sample
  );
  gdio_pin_model #(.N_PINS(8)) u_pins (
    .i_clk_sys, .i_pin_out(o_pin_out), .i_pin_oe_n(o_pin_oe_n),
    .i_pullup_en(o_pullup_en), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin_level(i_pin_level)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each transfer starts at a fresh edge, which leaves one idle cycle between.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rdata = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("read %h", a), exp, rdata);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  initial begin
    i_sys_rst = 1'b1;
    {i_psel, i_penable, i_pwrite, i_sleep_clamp, i_paddr, i_pwdata, i_pstrb} = '0;
    {i_ext_int_en, i_alt_input_keep, ext_val} = '0;
    ext_en = 8'hff;
    repeat (3) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    foreach (regs[i]) rdc(regs[i], 32'h0);
    $display("test reset done");
    wr(`GDIO_OFF_OUT, 32'ha5);
    wr(`GDIO_OFF_PULLUP, 32'h3c);
    wr(`GDIO_OFF_SAMPLE, 32'h0f);
    apb(1'b1, `GDIO_OFF_OUT, 32'hff, 4'h0);
    rdc(`GDIO_OFF_OUT, 32'haa);
    rdc(`GDIO_OFF_PULLUP, 32'h3c);
    rdc(`GDIO_OFF_SAMPLE, 32'h0);
    $display("test registers done");
    wr(`GDIO_OFF_DIR, 32'hff);
    step(1);
    chk("oe_n", 32'h00, o_pin_oe_n);
    chk("pin out", 32'haa, o_pin_out);
    chk("pullup", 32'h3c, o_pullup_en);
    rdc(`GDIO_OFF_SAMPLE, 32'haa);
    rdc(`GDIO_OFF_STATUS, 32'hff00);
    $display("test drive done");
    wr(`GDIO_OFF_DIR, 32'h00);
    wr(`GDIO_OFF_CTRL, 32'h1);
    wr(`GDIO_OFF_DIR, 32'h0f);
    step(1);
    chk("oe_n gap", 32'hff, o_pin_oe_n);
    step(1);
    chk("oe_n after gap", 32'hf0, o_pin_oe_n);
    wr(`GDIO_OFF_DIR, 32'h03);
    step(1);
    chk("oe_n release", 32'hfc, o_pin_oe_n);
    wr(`GDIO_OFF_DIR, 32'h00);
    wr(`GDIO_OFF_CTRL, 32'h0);
    wr(`GDIO_OFF_PULLUP, 32'hf0);
    $display("test bbm done");
    @(posedge i_clk_sys);
    ext_en <= 8'h0f;
    ext_val <= 8'h0a;
    step(1);
    chk("sample early", 32'h00, o_pin_sample);
    step(1);
    chk("sample", 32'hfa, o_pin_sample);
    rdc(`GDIO_OFF_SAMPLE, 32'hfa);
    @(posedge i_clk_sys);
    i_sleep_clamp <= 1'b1;
    i_ext_int_en <= 8'h01;
    i_alt_input_keep <= 8'h02;
    step(3);
    chk("clamped", 32'h02, o_pin_sample);
    rdc(`GDIO_OFF_STATUS, 32'h1);
    @(posedge i_clk_sys);
    i_sleep_clamp <= 1'b0;
    step(3);
    chk("unclamped", 32'hfa, o_pin_sample);
    $display("test input done");
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("read error", 32'h1, serr);
    chk("read data", 32'h0, rdata);
    wr(8'h1c, 32'hff);
    chk("write error", 32'h1, serr);
    wr(`GDIO_OFF_DIR, 32'hff);
    step(1);
    chk("oe_n before reset", 32'h00, o_pin_oe_n);
    // Reset is raised on an edge; the pins must let go at once, not at the next edge.
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    #10;
    chk("oe_n reset", 32'hff, o_pin_oe_n);
    chk("pullup reset", 32'h0, o_pullup_en);
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rdc(`GDIO_OFF_DIR, 32'h0);
    $display("test errors and reset done");
    end_sim();
  end
endmodule
